// *** adc_regs_defines.vh ***
`ifndef ADC_REGS_DEFINES_VH
`define ADC_REGS_DEFINES_VH

// Register offsets on the serial port
`define OFS_STATUS 8'h00
`define OFS_GCTRL 8'h01

// Reset values
`define RST_STATUS 8'h81
`define RST_GCTRL 8'h00

// Status register fields
`define ST_RSVD_ONE 7
`define ST_SEQ 6
`define ST_HS 5
`define ST_RSVD_ZERO 4
`define ST_AVG 3
`define ST_FUSE 2
`define ST_CRCIN 1
`define ST_BOR 0

// Global control register fields
`define GC_RSVD 7
`define GC_CRC 6
`define GC_STATS 5
`define GC_WIN 4
`define GC_TRIG 3
`define GC_FORCE 2
`define GC_CAL 1
`define GC_SRST 0

// Serial target address, arbitrary
`define TARGET_ADDR 7'h17

// Bit count that marks the acknowledge slot
`define ACK_SLOT 4'h8
`define LAST_DATA_BIT 4'h7
// Preset at start; the start's own clock fall wraps it to zero
`define START_CNT 4'hf

`endif

// *** adc_status_ctrl.v ***
`include "adc_regs_defines.vh"

module adc_status_ctrl (
  input wire MCLK_I,
  input wire RST_N_I,
  input wire SCL_I,
  input wire SDA_I,
  output wire SCL_O,
  output wire SCL_OE_N_O,
  output wire SDA_O,
  output wire SDA_OE_N_O,
  input wire SEQUENCER_ACTIVE_I,
  input wire HS_MODE_I,
  input wire MANUAL_MODE_I,
  input wire AVERAGE_DONE_I,
  input wire POWERUP_CONFIG_CRC_FAIL_I,
  input wire CRC_MISMATCH_I,
  input wire BROWNOUT_EVENT_I,
  input wire RESUME_ON_ERROR_OPTION_I,
  input wire CONV_DONE_I,
  input wire CAL_DONE_I,
  input wire [7:0] EXT_RDATA_I,
  output wire CRC_ENABLE_O,
  output wire STATISTICS_ENABLE_O,
  output wire STATISTICS_CLEAR_O,
  output wire WINDOW_COMPARATOR_ENABLE_O,
  output wire WINDOW_COMPARATOR_RESET_O,
  output wire CONV_START_O,
  output wire FORCE_ALL_ANALOG_O,
  output wire SEQ_PAUSE_O,
  output wire CAL_START_O,
  output wire SOFT_RESET_O,
  output wire EXT_WR_O,
  output wire [7:0] EXT_ADDR_O,
  output wire [7:0] EXT_WDATA_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Shared by the three host-clearable flags
  // Sticky flag update, set wins over clear
  function w1c;
    input cur;
    input set;
    input clr;
    begin
      w1c = set | (cur & ~clr);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  wire sda_oe_n; // Serial target data drive
  wire [7:0] ptr; // Register pointer
  wire wr_stb; // Byte written
  wire [7:0] wd; // Written byte
  wire rd_nine; // Ninth falling edge of read frame
  reg [7:0] rd_data; // Read-back mux

  reg seq_q; // Sequencer activity copy
  reg hs_q; // High-speed mode copy
  reg avg_q; // Averaging complete flag
  reg fuse_q; // Config CRC fail flag
  reg fuse_cap_q; // Capture of config CRC pending
  reg crc_err_q; // Incoming CRC error flag
  reg bor_q; // Brown-out flag
  reg crc_en_q; // Interface CRC enable
  reg stats_q; // Statistics enable
  reg stats_clr_q; // Statistics clear pulse
  reg win_q; // Window comparator enable
  reg win_rst_q; // Window comparator reset pulse
  reg force_q; // Force all analog bit
  reg cal_q; // Calibration in progress
  reg cal_start_q; // Calibration start pulse
  reg srst_q; // Soft reset pulse
  reg conv_q; // Conversion start pulse
  reg scl_oe_n_q; // Low while stretching SCL
  reg force_out_q; // Effective force analog
  reg pause_q; // Sequencing pause
  reg ext_wr_q; // Forwarded write strobe
  reg [7:0] ext_addr_q; // Forwarded write address
  reg [7:0] ext_wd_q; // Forwarded write data
  reg zero_q; // Constant low for open-drain pins

  // Write strobe decoded against the two local offsets
  wire st_wr = wr_stb & (ptr == `OFS_STATUS);
  wire gc_wr = wr_stb & (ptr == `OFS_GCTRL);
  wire local_hit = (ptr == `OFS_STATUS) | (ptr == `OFS_GCTRL);
  wire crc_set = CRC_MISMATCH_I & crc_en_q;
  // Read frame start, ignored while already stretching
  wire stretch_go = rd_nine & MANUAL_MODE_I & scl_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial target

  // Pins pass the synchronisers inside before any decoding
  i2c_target u_target (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .rd_data_i(rd_data),
    .sda_oe_n_o(sda_oe_n),
    .ptr_o(ptr),
    .wr_stb_o(wr_stb),
    .wr_data_o(wd),
    .rd_ninth_fall_o(rd_nine)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read-back mux
  // Local registers answer here, any other offset is
  // served by the rest of the register map
  always @* begin
    case (ptr)
      `OFS_STATUS: begin
        rd_data = {1'b1, seq_q, hs_q, 1'b0, avg_q, fuse_q, crc_err_q, bor_q};
      end
      `OFS_GCTRL: begin
        // Trigger and soft reset read zero
        rd_data = {1'b0, crc_en_q, stats_q, win_q, 1'b0, force_q, cal_q, 1'b0};
      end
      default: begin
        rd_data = EXT_RDATA_I;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register
  // A host clear loses against a same-cycle set, so an
  // event landing during the clear is never dropped
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      seq_q <= 1'b0;
      hs_q <= 1'b0;
      avg_q <= 1'b0;
      fuse_q <= 1'b0;
      fuse_cap_q <= 1'b1;
      crc_err_q <= 1'b0;
      bor_q <= 1'b1;
    end else begin
      // Read-only live copies
      // They lag their inputs by one cycle
      seq_q <= SEQUENCER_ACTIVE_I;
      hs_q <= HS_MODE_I;
      // Config CRC result taken once after reset
      if (fuse_cap_q) begin
        fuse_q <= POWERUP_CONFIG_CRC_FAIL_I;
      end
      fuse_cap_q <= srst_q;
      if (srst_q) begin
        // Defaults, brown-out raised
        avg_q <= AVERAGE_DONE_I;
        crc_err_q <= 1'b0;
        bor_q <= 1'b1;
      end else begin
        avg_q <= w1c(avg_q, AVERAGE_DONE_I, st_wr & wd[`ST_AVG]);
        crc_err_q <= w1c(crc_err_q, crc_set, st_wr & wd[`ST_CRCIN]);
        bor_q <= w1c(bor_q, BROWNOUT_EVENT_I, st_wr & wd[`ST_BOR]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global control register
  // Soft reset acts one cycle after its strobe, so it
  // overrides the level bits of the same write, not its pulses
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      crc_en_q <= 1'b0;
      stats_q <= 1'b0;
      stats_clr_q <= 1'b0;
      win_q <= 1'b0;
      win_rst_q <= 1'b0;
      force_q <= 1'b0;
      cal_q <= 1'b0;
      cal_start_q <= 1'b0;
      srst_q <= 1'b0;
    end else begin
      // Pulses last one cycle unless reloaded below
      stats_clr_q <= 1'b0;
      win_rst_q <= 1'b0;
      cal_start_q <= 1'b0;
      srst_q <= gc_wr & wd[`GC_SRST];
      if (srst_q) begin
        // Defaults after soft reset
        crc_en_q <= 1'b0;
        stats_q <= 1'b0;
        win_q <= 1'b0;
        win_rst_q <= 1'b1;
        force_q <= 1'b0;
        cal_q <= 1'b0;
      end else if (gc_wr) begin
        crc_en_q <= wd[`GC_CRC];
        stats_q <= wd[`GC_STATS];
        // Clear only when statistics turn on
        stats_clr_q <= wd[`GC_STATS] & ~stats_q;
        win_q <= wd[`GC_WIN];
        win_rst_q <= ~wd[`GC_WIN];
        force_q <= wd[`GC_FORCE];
        cal_q <= wd[`GC_CAL] | (cal_q & ~CAL_DONE_I);
        cal_start_q <= wd[`GC_CAL] & ~cal_q;
      end else if (CAL_DONE_I) begin
        // Calibration finished
        cal_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion start and clock stretching
  // Only manual mode read frames stretch; conversion end
  // or soft reset lets the bus clock go again
  // The trigger bit pulses once and never stretches
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      conv_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
    end else begin
      // Trigger bit starts at once, read frame on ninth edge
      conv_q <= (gc_wr & wd[`GC_TRIG]) | stretch_go;
      if (stretch_go) begin
        // Hold the bus clock low
        scl_oe_n_q <= 1'b0;
      end else if (CONV_DONE_I | srst_q) begin
        scl_oe_n_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error response and forwarded writes
  // Registered so every output leaves a flop; forwarded
  // writes follow one cycle after the write strobe
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      force_out_q <= 1'b0;
      pause_q <= 1'b0;
      ext_wr_q <= 1'b0;
      ext_addr_q <= 8'h00;
      ext_wd_q <= 8'h00;
      zero_q <= 1'b0;
    end else begin
      zero_q <= 1'b0;
      // Error with resume option forces analog and pauses
      force_out_q <= force_q | (RESUME_ON_ERROR_OPTION_I & crc_err_q);
      // Clearing the flag resumes and restores pins
      pause_q <= RESUME_ON_ERROR_OPTION_I & crc_err_q;
      // Writes elsewhere dropped while CRC error stands
      ext_wr_q <= wr_stb & ~local_hit & ~crc_err_q;
      if (wr_stb) begin
        ext_addr_q <= ptr;
        ext_wd_q <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Open-drain pins only pull low; enables pick when
  assign SCL_O = zero_q;
  assign SDA_O = zero_q;
  assign SCL_OE_N_O = scl_oe_n_q;
  assign SDA_OE_N_O = sda_oe_n;
  // Control levels and pulses straight from flops
  assign CRC_ENABLE_O = crc_en_q;
  assign STATISTICS_ENABLE_O = stats_q;
  assign STATISTICS_CLEAR_O = stats_clr_q;
  assign WINDOW_COMPARATOR_ENABLE_O = win_q;
  assign WINDOW_COMPARATOR_RESET_O = win_rst_q;
  assign CONV_START_O = conv_q;
  assign FORCE_ALL_ANALOG_O = force_out_q;
  assign SEQ_PAUSE_O = pause_q;
  assign CAL_START_O = cal_start_q;
  assign SOFT_RESET_O = srst_q;
  assign EXT_WR_O = ext_wr_q;
  assign EXT_ADDR_O = ext_addr_q;
  assign EXT_WDATA_O = ext_wd_q;

endmodule // adc_status_ctrl

// *** adc_status_ctrl_monitor.sv ***
module adc_status_ctrl_monitor (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic MANUAL_MODE_I,
  input wire logic CONV_DONE_I,
  input wire logic RESUME_ON_ERROR_OPTION_I,
  input wire logic SCL_O,
  input wire logic SCL_OE_N_O,
  input wire logic SDA_O,
  input wire logic CRC_ENABLE_O,
  input wire logic STATISTICS_ENABLE_O,
  input wire logic STATISTICS_CLEAR_O,
  input wire logic WINDOW_COMPARATOR_ENABLE_O,
  input wire logic WINDOW_COMPARATOR_RESET_O,
  input wire logic CONV_START_O,
  input wire logic FORCE_ALL_ANALOG_O,
  input wire logic SEQ_PAUSE_O,
  input wire logic SOFT_RESET_O,
  input wire logic EXT_WR_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  //////////////////////////////////////////////////////////
  // Enables all dropped
  sequence cleared_s;
    !(CRC_ENABLE_O | STATISTICS_ENABLE_O | WINDOW_COMPARATOR_ENABLE_O);
  endsequence
  // Pulse gone, then enables cleared shortly
  sequence srst_done_s;
    !SOFT_RESET_O ##[0:2] cleared_s;
  endsequence
  // Held clock let go soon after conversion end
  sequence released_s;
    ##[1:2] SCL_OE_N_O;
  endsequence

  //////////////////////////////////////////////////////////
  pins_low_a: assert property (!SCL_O && !SDA_O)
    else $error("open drain pin driven high");
  stretch_cause_a: assert property ($fell(SCL_OE_N_O) |-> MANUAL_MODE_I &&
    (CONV_START_O || $past(CONV_START_O))) else $error("stretch without conversion");
  stretch_end_a: assert property (!SCL_OE_N_O && CONV_DONE_I |-> released_s)
    else $error("clock held after conversion end");
  trig_pulse_a: assert property (CONV_START_O |=> !CONV_START_O)
    else $error("conversion start too long");
  pause_force_a: assert property (SEQ_PAUSE_O |-> FORCE_ALL_ANALOG_O)
    else $error("pause without analog override");
  pause_gate_a: assert property ($rose(SEQ_PAUSE_O) |-> CRC_ENABLE_O &&
    RESUME_ON_ERROR_OPTION_I) else $error("error flagged with check off");
  blocked_write_a: assert property (EXT_WR_O && RESUME_ON_ERROR_OPTION_I
    |-> !SEQ_PAUSE_O) else $error("write forwarded during error");
  stats_clear_a: assert property (STATISTICS_CLEAR_O |-> ##[0:2] STATISTICS_ENABLE_O)
    else $error("statistics clear without enable");
  win_reset_a: assert property (WINDOW_COMPARATOR_RESET_O
    |-> ##[0:2] !WINDOW_COMPARATOR_ENABLE_O) else $error("comparator reset while on");
  soft_reset_a: assert property (SOFT_RESET_O |=> srst_done_s)
    else $error("soft reset left control set");
endmodule // adc_status_ctrl_monitor

bind adc_status_ctrl adc_status_ctrl_monitor mon (.MCLK_I, .RST_N_I, .MANUAL_MODE_I,
  .CONV_DONE_I, .RESUME_ON_ERROR_OPTION_I, .SCL_O, .SCL_OE_N_O, .SDA_O, .CRC_ENABLE_O,
  .STATISTICS_ENABLE_O, .STATISTICS_CLEAR_O, .WINDOW_COMPARATOR_ENABLE_O,
  .WINDOW_COMPARATOR_RESET_O, .CONV_START_O, .FORCE_ALL_ANALOG_O, .SEQ_PAUSE_O,
  .SOFT_RESET_O, .EXT_WR_O);

// *** i2c_host_model.sv ***
`include "adc_regs_defines.vh"

module i2c_host_model (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] n_nak; // Bytes the target left unacknowledged

  // Both lines released while idle
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    n_nak = 8'h00;
  end

  //////////////////////////////////////////////////////////
  // One 80 ns bit; waits out a held-low clock
  task automatic slot(input logic b, output logic r);
    int n;
    sda_o = b;
    #20 scl_o = 1'b1;
    #10;
    for (n = 0; n < 9000 && scl_i !== 1'b1; n++) #10;
    #10 r = sda_i;
    #20 scl_o = 1'b0;
    #20;
  endtask

  // Eight bits MSB first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic k);
    for (int i = 7; i >= 0; i--) slot(d[i], q[i]);
    slot(a, k);
  endtask

  // Data line falls while the clock is high
  task automatic start;
    sda_o = 1'b1;
    scl_o = 1'b1;
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b0;
    #20;
  endtask

  // Data line rises while the clock is high
  task automatic stop;
    sda_o = 1'b0;
    #20 scl_o = 1'b1;
    #40 sda_o = 1'b1;
    #40;
  endtask

  // Byte out, acknowledge expected
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic k;
    xfer(d, 1'b1, q, k);
    if (k !== 1'b0) n_nak = n_nak + 8'h01;
  endtask

  // Register write frame
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    send({`TARGET_ADDR, 1'b0});
    send(a);
    send(d);
    stop();
  endtask

  // Pointer frame, then a one-byte read frame
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic k;
    start();
    send({`TARGET_ADDR, 1'b0});
    send(a);
    stop();
    start();
    send({`TARGET_ADDR, 1'b1});
    xfer(8'hff, 1'b1, q, k);
    stop();
  endtask
endmodule // i2c_host_model

// *** i2c_target.v ***
`include "adc_regs_defines.vh"

module i2c_target (
  input wire clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  input wire [7:0] rd_data_i,
  output wire sda_oe_n_o,
  output wire [7:0] ptr_o,
  output wire wr_stb_o,
  output wire [7:0] wr_data_o,
  output wire rd_ninth_fall_o
);

  // One-hot frame states
  localparam S_IDLE = 5'h01;
  localparam S_ADDR = 5'h02;
  localparam S_PTR = 5'h04;
  localparam S_WR = 5'h08;
  localparam S_RD = 5'h10;

  reg [1:0] scl_s_q; // Two-stage pin synchroniser
  reg [1:0] sda_s_q; // Two-stage pin synchroniser
  reg scl_p_q; // Previous synchronised level
  reg sda_p_q; // Previous synchronised level
  reg [4:0] state_q; // Frame state
  reg [3:0] cnt_q; // Falling edges within byte
  reg [7:0] sh_q; // Byte shifter
  reg rw_q; // Direction from address byte
  reg nack_q; // Host did not acknowledge
  reg oe_n_q; // Low while pulling SDA low
  reg [7:0] ptr_q; // Register pointer
  reg wr_q; // Write strobe
  reg [7:0] wd_q; // Write data
  reg nine_q; // Ninth falling edge after read address

  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire rise = scl & ~scl_p_q;
  wire fall = ~scl & scl_p_q;
  wire start = scl & scl_p_q & sda_p_q & ~sda;
  wire stop = scl & scl_p_q & ~sda_p_q & sda;

  assign sda_oe_n_o = oe_n_q;
  assign ptr_o = ptr_q;
  assign wr_stb_o = wr_q;
  assign wr_data_o = wd_q;
  assign rd_ninth_fall_o = nine_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge history
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_n_q <= 1'b1;
      ptr_q <= 8'h00;
      wr_q <= 1'b0;
      wd_q <= 8'h00;
      nine_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      nine_q <= 1'b0;
      if (start) begin
        // Start or repeated start
        state_q <= S_ADDR;
        cnt_q <= `START_CNT;
        oe_n_q <= 1'b1;
      end else if (stop) begin
        state_q <= S_IDLE;
        oe_n_q <= 1'b1;
      end else if (state_q != S_IDLE) begin
        // Sample on rising edge
        if (rise) begin
          if (cnt_q == `ACK_SLOT) begin
            nack_q <= sda;
          end else if (state_q != S_RD) begin
            sh_q <= {sh_q[6:0], sda};
          end
        end
        if (fall) begin
          if (cnt_q == `LAST_DATA_BIT) begin
            // Byte done, acknowledge slot follows
            cnt_q <= `ACK_SLOT;
            case (state_q)
              S_RD: begin
                oe_n_q <= 1'b1;
                ptr_q <= ptr_q + 8'h01;
              end
              S_ADDR: begin
                if (sh_q[7:1] == `TARGET_ADDR) begin
                  oe_n_q <= 1'b0;
                  rw_q <= sh_q[0];
                end else begin
                  state_q <= S_IDLE;
                end
              end
              S_PTR: begin
                oe_n_q <= 1'b0;
                ptr_q <= sh_q;
              end
              default: begin
                oe_n_q <= 1'b0;
                wd_q <= sh_q;
                wr_q <= 1'b1;
              end
            endcase
          end else if (cnt_q == `ACK_SLOT) begin
            // Ninth falling edge
            cnt_q <= 4'h0;
            case (state_q)
              S_ADDR: begin
                if (rw_q) begin
                  state_q <= S_RD;
                  sh_q <= rd_data_i;
                  oe_n_q <= rd_data_i[7];
                  nine_q <= 1'b1;
                end else begin
                  state_q <= S_PTR;
                  oe_n_q <= 1'b1;
                end
              end
              S_PTR: begin
                state_q <= S_WR;
                oe_n_q <= 1'b1;
              end
              S_RD: begin
                if (nack_q) begin
                  state_q <= S_IDLE;
                  oe_n_q <= 1'b1;
                end else begin
                  sh_q <= rd_data_i;
                  oe_n_q <= rd_data_i[7];
                end
              end
              default: begin
                oe_n_q <= 1'b1;
                ptr_q <= ptr_q + 8'h01;
              end
            endcase
          end else begin
            cnt_q <= cnt_q + 4'h1;
            // Shift out next read bit
            if (state_q == S_RD) begin
              oe_n_q <= sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
        end
      end
    end
  end

endmodule // i2c_target

// *** tb_adc_status_and_global_control.sv ***
module tb_adc_status_and_global_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic SEQUENCER_ACTIVE_I = 1'b0, HS_MODE_I = 1'b0, MANUAL_MODE_I = 1'b0;
  logic AVERAGE_DONE_I = 1'b0, POWERUP_CONFIG_CRC_FAIL_I = 1'b0, CRC_MISMATCH_I = 1'b0;
  logic BROWNOUT_EVENT_I = 1'b0, RESUME_ON_ERROR_OPTION_I = 1'b1, CONV_DONE_I = 1'b0;
  logic CAL_DONE_I = 1'b0;
  logic [7:0] EXT_RDATA_I = 8'h5a;
  wire h_scl, h_sda;
  wire SCL_O, SCL_OE_N_O, SDA_O, SDA_OE_N_O, CRC_ENABLE_O, STATISTICS_ENABLE_O;
  wire STATISTICS_CLEAR_O, WINDOW_COMPARATOR_ENABLE_O, WINDOW_COMPARATOR_RESET_O;
  wire CONV_START_O, FORCE_ALL_ANALOG_O, SEQ_PAUSE_O, CAL_START_O, SOFT_RESET_O, EXT_WR_O;
  wire [7:0] EXT_ADDR_O, EXT_WDATA_O;
  // Open-drain lines with pull-ups
  wire SCL_I = h_scl & (SCL_OE_N_O ? 1'b1 : SCL_O);
  wire SDA_I = h_sda & (SDA_OE_N_O ? 1'b1 : SDA_O);
  // Pulse tallies since the last clear
  logic [7:0] n_ext = 8'h00, n_sc = 8'h00, n_wr = 8'h00, n_cs = 8'h00;
  logic [7:0] n_cal = 8'h00, n_sr = 8'h00, n_st = 8'h00, ext_a, ext_d;
  int n_mismatch = 0, num_checks = 0, cyc = 0;

  adc_status_ctrl uut (.MCLK_I, .RST_N_I, .SCL_I, .SDA_I, .SCL_O, .SCL_OE_N_O, .SDA_O,
    .SDA_OE_N_O, .SEQUENCER_ACTIVE_I, .HS_MODE_I, .MANUAL_MODE_I, .AVERAGE_DONE_I,
    .POWERUP_CONFIG_CRC_FAIL_I, .CRC_MISMATCH_I, .BROWNOUT_EVENT_I,
    .RESUME_ON_ERROR_OPTION_I, .CONV_DONE_I, .CAL_DONE_I, .EXT_RDATA_I, .CRC_ENABLE_O,
    .STATISTICS_ENABLE_O, .STATISTICS_CLEAR_O, .WINDOW_COMPARATOR_ENABLE_O,
    .WINDOW_COMPARATOR_RESET_O, .CONV_START_O, .FORCE_ALL_ANALOG_O, .SEQ_PAUSE_O,
    .CAL_START_O, .SOFT_RESET_O, .EXT_WR_O, .EXT_ADDR_O, .EXT_WDATA_O);
  i2c_host_model host (.scl_i(SCL_I), .sda_i(SDA_I), .scl_o(h_scl), .sda_o(h_sda));

  always #5 MCLK_I = ~MCLK_I;

  //////////////////////////////////////////////////////////
  // Tally pulses, stretch cycles; hang guard
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    if (EXT_WR_O === 1'b1) begin
      n_ext <= n_ext + 8'h01;
      ext_a <= EXT_ADDR_O;
      ext_d <= EXT_WDATA_O;
    end
    if (STATISTICS_CLEAR_O === 1'b1) n_sc <= n_sc + 8'h01;
    if (WINDOW_COMPARATOR_RESET_O === 1'b1) n_wr <= n_wr + 8'h01;
    if (CONV_START_O === 1'b1) n_cs <= n_cs + 8'h01;
    if (CAL_START_O === 1'b1) n_cal <= n_cal + 8'h01;
    if (SOFT_RESET_O === 1'b1) n_sr <= n_sr + 8'h01;
    if (SCL_OE_N_O === 1'b0) n_st <= n_st + 8'h01;
    if (cyc == 60000) begin
      bad("timeout");
      results();
    end
  end

  //////////////////////////////////////////////////////////
  function automatic logic differs(input logic [7:0] v, input logic [7:0] e);
    num_checks++;
    return v !== e;
  endfunction
  task automatic bad(input string m);
    n_mismatch++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic eq(input logic [7:0] v, input logic [7:0] e, input string m);
    if (differs(v, e)) bad(m);
  endtask
  task automatic flag(input logic f, input logic e, input string m);
    if (differs({7'h00, f}, {7'h00, e})) bad(m);
  endtask
  // Clear tallies between edges
  task automatic zap;
    @(negedge MCLK_I);
    {n_ext, n_sc, n_wr, n_cs, n_cal, n_sr, n_st} = '0;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK_I);
    host.wr(a, d);
  endtask
  task automatic rd_is(input logic [7:0] a, input logic [7:0] e, input string m);
    logic [7:0] v;
    @(negedge MCLK_I);
    host.rd(a, v);
    if (differs(v, e)) bad(m);
  endtask

  //////////////////////////////////////////////////////////
  task automatic t_live;
    rd_is(8'h00, 8'h81, "status reset");
    rd_is(8'h01, 8'h00, "control reset");
    @(posedge MCLK_I);
    SEQUENCER_ACTIVE_I <= 1'b1;
    HS_MODE_I <= 1'b1;
    w(8'h00, 8'hff);
    rd_is(8'h00, 8'he0, "live bits");
    @(posedge MCLK_I);
    SEQUENCER_ACTIVE_I <= 1'b0;
    HS_MODE_I <= 1'b0;
  endtask
  task automatic t_flags;
    @(posedge MCLK_I);
    AVERAGE_DONE_I <= 1'b1;
    BROWNOUT_EVENT_I <= 1'b1;
    @(posedge MCLK_I);
    AVERAGE_DONE_I <= 1'b0;
    BROWNOUT_EVENT_I <= 1'b0;
    rd_is(8'h00, 8'h89, "flags set");
    w(8'h00, 8'h00);
    rd_is(8'h00, 8'h89, "zero write kept");
    @(posedge MCLK_I);
    AVERAGE_DONE_I <= 1'b1;
    w(8'h00, 8'h09);
    @(posedge MCLK_I);
    AVERAGE_DONE_I <= 1'b0;
    rd_is(8'h00, 8'h88, "set lost to clear");
    w(8'h00, 8'h09);
    rd_is(8'h00, 8'h80, "flags cleared");
  endtask
  task automatic t_crc;
    @(posedge MCLK_I);
    CRC_MISMATCH_I <= 1'b1;
    @(posedge MCLK_I);
    CRC_MISMATCH_I <= 1'b0;
    rd_is(8'h00, 8'h80, "mismatch with check off");
    w(8'h01, 8'h40);
    flag(CRC_ENABLE_O, 1'b1, "check enable");
    @(posedge MCLK_I);
    CRC_MISMATCH_I <= 1'b1;
    @(posedge MCLK_I);
    CRC_MISMATCH_I <= 1'b0;
    rd_is(8'h00, 8'h82, "input error");
    flag(SEQ_PAUSE_O & FORCE_ALL_ANALOG_O, 1'b1, "pause on error");
    zap();
    w(8'h05, 8'h3c);
    eq(n_ext, 8'h00, "write not blocked");
    w(8'h00, 8'h02);
    rd_is(8'h00, 8'h80, "error not cleared");
    flag(SEQ_PAUSE_O | FORCE_ALL_ANALOG_O, 1'b0, "no resume");
    w(8'h05, 8'h3c);
    eq(n_ext, 8'h01, "write lost");
    eq(ext_a, 8'h05, "write address");
    eq(ext_d, 8'h3c, "write data");
  endtask
  task automatic t_ctrl;
    zap();
    w(8'h01, 8'hb4);
    eq(n_sc, 8'h01, "statistics clear");
    flag(STATISTICS_ENABLE_O & WINDOW_COMPARATOR_ENABLE_O, 1'b1, "enables");
    flag(FORCE_ALL_ANALOG_O, 1'b1, "analog override");
    rd_is(8'h01, 8'h34, "control readback");
    zap();
    w(8'h01, 8'h00);
    eq(n_wr, 8'h01, "comparator reset");
    flag(WINDOW_COMPARATOR_ENABLE_O | FORCE_ALL_ANALOG_O, 1'b0, "enables off");
    zap();
    w(8'h01, 8'h08);
    eq(n_cs, 8'h01, "trigger start");
    eq(n_st, 8'h00, "trigger stretched");
    rd_is(8'h01, 8'h00, "trigger readback");
    zap();
    w(8'h01, 8'h02);
    eq(n_cal, 8'h01, "calibration start");
    rd_is(8'h01, 8'h02, "calibration busy");
    @(posedge MCLK_I);
    CAL_DONE_I <= 1'b1;
    @(posedge MCLK_I);
    CAL_DONE_I <= 1'b0;
    rd_is(8'h01, 8'h00, "calibration stuck");
  endtask
  task automatic t_conv;
    @(posedge MCLK_I);
    MANUAL_MODE_I <= 1'b1;
    zap();
    fork
      rd_is(8'h01, 8'h00, "data after stretch");
      begin
        for (int i = 0; i < 900 && CONV_START_O !== 1'b1; i++) @(posedge MCLK_I);
        repeat (20) @(posedge MCLK_I);
        CONV_DONE_I <= 1'b1;
        @(posedge MCLK_I);
        CONV_DONE_I <= 1'b0;
      end
    join
    eq(n_cs, 8'h01, "read frame start");
    flag(n_st > 8'd19, 1'b1, "clock not held");
    @(posedge MCLK_I);
    MANUAL_MODE_I <= 1'b0;
  endtask
  task automatic t_srst;
    @(posedge MCLK_I);
    POWERUP_CONFIG_CRC_FAIL_I <= 1'b1;
    w(8'h01, 8'h70);
    zap();
    w(8'h01, 8'h01);
    eq(n_sr, 8'h01, "soft reset pulse");
    flag(CRC_ENABLE_O | STATISTICS_ENABLE_O, 1'b1 ^ 1'b1, "enables kept");
    rd_is(8'h01, 8'h00, "control defaults");
    rd_is(8'h00, 8'h85, "status after reset");
    eq(host.n_nak, 8'h00, "byte not acked");
  endtask

  //////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Reset, then every scenario in turn
  initial begin
    repeat (3) @(posedge MCLK_I);
    RST_N_I <= 1'b1;
    repeat (3) @(posedge MCLK_I);
    t_live();
    t_flags();
    t_crc();
    t_ctrl();
    t_conv();
    t_srst();
    results();
  end
endmodule // tb_adc_status_and_global_control
